// ### common/lsct_pkg.sv
// Shared constants and types for the load/store cycle timing block
package lsct_pkg;
	typedef enum logic [4:0] {
		LSCT_OP_ALU,
		LSCT_OP_SSRF,
		LSCT_OP_MTSR,
		LSCT_OP_MAC,
		LSCT_OP_MACSD,
		LSCT_OP_MULWH,
		LSCT_OP_LD,
		LSCT_OP_LDPI,
		LSCT_OP_ST,
		LSCT_OP_LDM,
		LSCT_OP_STM,
		LSCT_OP_RMW
	} lsct_op_t;

	localparam int  LSCT_CNT_W       = 6;
	localparam int  LSCT_REG_W       = 4;
	localparam int  LSCT_SYSREG_W    = 8;
	localparam int  LSCT_WS_W        = 4;
	localparam logic [7:0]  LSCT_STATUS_SYSREG = 8'h00;
	localparam logic [4:0]  LSCT_UPPER_BIT     = 5'h10;
	localparam logic [LSCT_CNT_W-1:0] LSCT_CYC_ONE   = 6'h01;
	localparam logic [LSCT_CNT_W-1:0] LSCT_CYC_TWO   = 6'h02;
	localparam logic [LSCT_CNT_W-1:0] LSCT_CYC_THREE = 6'h03;
	localparam logic [LSCT_CNT_W-1:0] LSCT_CYC_FOUR  = 6'h04;
	localparam logic [1:0]  LSCT_RMW_SHADOW   = 2'h3;
	localparam logic [1:0]  LSCT_BST_SHADOW   = 2'h2;
	localparam logic [5:0]  LSCT_PROD_W       = 6'h30;
endpackage : lsct_pkg

// ### rtl/lsct_core.sv
// Execute-stage cycle timing for loads, stores, multiplies and atomic bit ops
`timescale 1ns/1ps
module lsct_core (
	input  wire logic                              clk,
	input  wire logic                              nrst,
	input  wire logic                              issue_valid,
	output logic                                   issue_ready,
	input  wire lsct_pkg::lsct_op_t                issue_op,
	input  wire logic                              issue_bus,
	input  wire logic [4:0]                        issue_flag_bit,
	input  wire logic [lsct_pkg::LSCT_SYSREG_W-1:0] issue_sysreg,
	input  wire logic [lsct_pkg::LSCT_REG_W-1:0]   issue_acc_reg,
	input  wire logic [lsct_pkg::LSCT_REG_W:0]     issue_reg_count,
	input  wire logic [31:0]                       mul_a,
	input  wire logic [15:0]                       mul_b,
	input  wire logic [lsct_pkg::LSCT_WS_W-1:0]    bus_wait_states,
	output logic                                   done,
	output logic [lsct_pkg::LSCT_CNT_W-1:0]        last_cycles,
	output logic [47:0]                            wide_product,
	output logic                                   wb_busy,
	output logic                                   stalled
);
	import lsct_pkg::*;

	logic                  rst_meta_r;
	logic                  rst_n_r;
	logic [LSCT_CNT_W-1:0] cnt_r;
	logic [LSCT_CNT_W-1:0] need;
	logic [LSCT_CNT_W-1:0] stall_need;
	logic [LSCT_CNT_W-1:0] base;
	logic [LSCT_CNT_W-1:0] rmw_ws;
	logic [LSCT_REG_W-1:0] acc_tag_r;
	logic                  acc_valid_r;
	logic                  acc_hit;
	logic [1:0]            rmw_shadow_r;
	logic [1:0]            bst_shadow_r;
	logic                  prev_bst_r;
	logic                  wb_full_r;
	logic                  is_mem;
	logic                  taken;
	logic [LSCT_CNT_W-1:0] regs;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	assign regs    = {1'b0, issue_reg_count};
	assign acc_hit = acc_valid_r && (acc_tag_r == issue_acc_reg);
	assign is_mem  = (issue_op == LSCT_OP_LD) || (issue_op == LSCT_OP_LDPI) || (issue_op == LSCT_OP_ST)
		|| (issue_op == LSCT_OP_LDM) || (issue_op == LSCT_OP_STM) || (issue_op == LSCT_OP_RMW);
	assign rmw_ws  = {2'b00, bus_wait_states};

	// Base execution cycles per instruction class
	always_comb begin
		base = LSCT_CYC_ONE;
		case (issue_op)
			LSCT_OP_SSRF:  base = (issue_flag_bit >= LSCT_UPPER_BIT) ? LSCT_CYC_THREE : LSCT_CYC_ONE;
			LSCT_OP_MTSR:  base = (issue_sysreg == LSCT_STATUS_SYSREG) ? LSCT_CYC_THREE : LSCT_CYC_ONE;
			LSCT_OP_MAC:   base = acc_hit ? LSCT_CYC_ONE : LSCT_CYC_TWO;
			LSCT_OP_MACSD: base = acc_hit ? LSCT_CYC_ONE : LSCT_CYC_FOUR;
			LSCT_OP_MULWH: base = LSCT_CYC_ONE;
			LSCT_OP_LD:    base = issue_bus ? LSCT_CYC_TWO : LSCT_CYC_ONE;
			LSCT_OP_LDPI:  base = LSCT_CYC_TWO;
			LSCT_OP_ST: begin
				if (issue_bus && prev_bst_r)
					base = LSCT_CYC_ONE;
				else if (issue_bus && bst_shadow_r != 2'b00)
					base = LSCT_CYC_TWO;
				else
					base = LSCT_CYC_ONE;
			end
			LSCT_OP_LDM:   base = issue_bus ? LSCT_CNT_W'(LSCT_CYC_ONE + (regs << 1))
				: LSCT_CNT_W'(LSCT_CYC_ONE + regs);
			LSCT_OP_STM:   base = issue_bus ? LSCT_CNT_W'(LSCT_CYC_TWO + regs) : LSCT_CNT_W'(LSCT_CYC_ONE + regs);
			LSCT_OP_RMW: begin
				if (issue_bus)
					base = LSCT_CNT_W'(LSCT_CYC_ONE + rmw_ws);
				else
					base = wb_full_r ? LSCT_CYC_TWO : LSCT_CYC_ONE;
			end
			default:       base = LSCT_CYC_ONE;
		endcase
	end

	// Stall owed to a background bus atomic op
	always_comb begin
		stall_need = '0;
		if (is_mem && rmw_shadow_r != 2'b00)
			stall_need = {4'h0, rmw_shadow_r};
	end

	assign need        = LSCT_CNT_W'(base + stall_need);
	assign issue_ready = (cnt_r == '0) || (cnt_r == LSCT_CYC_ONE);
	assign taken       = issue_valid && (cnt_r == '0);
	assign stalled     = (cnt_r > LSCT_CYC_ONE);

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cnt_r       <= '0;
			last_cycles <= '0;
			done        <= 1'b0;
		end else begin
			done <= 1'b0;
			if (taken) begin
				cnt_r       <= LSCT_CNT_W'(need - LSCT_CYC_ONE);
				last_cycles <= need;
				done        <= (need == LSCT_CYC_ONE);
			end else if (cnt_r != '0) begin
				cnt_r <= LSCT_CNT_W'(cnt_r - LSCT_CYC_ONE);
				done  <= (cnt_r == LSCT_CYC_ONE);
			end
		end
	end

	// Background shadows: bus atomic and bus store windows
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rmw_shadow_r <= '0;
			bst_shadow_r <= '0;
			prev_bst_r   <= 1'b0;
		end else if (taken) begin
			if (issue_op == LSCT_OP_RMW && issue_bus)
				rmw_shadow_r <= LSCT_RMW_SHADOW;
			else if (is_mem)
				rmw_shadow_r <= '0;
			else if (rmw_shadow_r != 2'b00)
				rmw_shadow_r <= rmw_shadow_r - 2'b01;
			// Bus write drains over three slots, so a later store that does not directly follow still pays the start cycle
			if (issue_op == LSCT_OP_ST && issue_bus)
				bst_shadow_r <= LSCT_RMW_SHADOW;
			else if (bst_shadow_r != 2'b00)
				bst_shadow_r <= bst_shadow_r - 2'b01;
			prev_bst_r <= (issue_op == LSCT_OP_ST) && issue_bus;
		end else if (cnt_r == '0 && rmw_shadow_r != 2'b00) begin
			rmw_shadow_r <= rmw_shadow_r - 2'b01;
		end
	end

	// Local write buffer and accumulator cache
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wb_full_r   <= 1'b0;
			acc_valid_r <= 1'b0;
			acc_tag_r   <= '0;
		end else if (taken) begin
			wb_full_r <= !issue_bus && ((issue_op == LSCT_OP_ST) || (issue_op == LSCT_OP_RMW));
			if (issue_op == LSCT_OP_MAC || issue_op == LSCT_OP_MACSD) begin
				acc_valid_r <= 1'b1;
				acc_tag_r   <= issue_acc_reg;
			end
		end else if (cnt_r == '0) begin
			wb_full_r <= 1'b0;
		end
	end
	assign wb_busy = wb_full_r;

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r)
			wide_product <= '0;
		else if (taken && issue_op == LSCT_OP_MULWH)
			wide_product <= 48'(mul_a) * 48'(mul_b);
	end

	property p_status_move;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_MTSR && issue_sysreg == LSCT_STATUS_SYSREG && rmw_shadow_r == 2'b00
			|=> last_cycles == LSCT_CYC_THREE ##2 done;
	endproperty
	a_status_move: assert property (p_status_move) else $error("status move not 3 cycles");

	property p_upper_flag;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_SSRF && issue_flag_bit >= LSCT_UPPER_BIT |=> !done ##1 !done ##1 done;
	endproperty
	a_upper_flag: assert property (p_upper_flag) else $error("upper flag set not 3 cycles");

	property p_local_load;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_LD && !issue_bus && rmw_shadow_r == 2'b00 |=> done && issue_ready;
	endproperty
	a_local_load: assert property (p_local_load) else $error("local load stalled");

	property p_bus_load;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_LD && issue_bus && rmw_shadow_r == 2'b00 |=> !done ##1 done;
	endproperty
	a_bus_load: assert property (p_bus_load) else $error("bus load not 2 cycles");

	property p_ldm_local;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_LDM && !issue_bus && rmw_shadow_r == 2'b00
			|=> last_cycles == LSCT_CNT_W'(LSCT_CYC_ONE + $past(regs));
	endproperty
	a_ldm_local: assert property (p_ldm_local) else $error("local load-multiple count wrong");

	property p_rmw_local;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_RMW && !issue_bus && rmw_shadow_r == 2'b00
			|=> last_cycles == ($past(wb_full_r) ? LSCT_CYC_TWO : LSCT_CYC_ONE);
	endproperty
	a_rmw_local: assert property (p_rmw_local) else $error("local atomic op count wrong");

	property p_rmw_stall;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_RMW && issue_bus ##1 taken && is_mem && issue_op == LSCT_OP_LD && !issue_bus
			|=> last_cycles == LSCT_CYC_FOUR;
	endproperty
	a_rmw_stall: assert property (p_rmw_stall) else $error("access after bus atomic not stalled 3");

	property p_bst_run;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_ST && issue_bus ##1 taken && issue_op == LSCT_OP_ST && issue_bus
			|=> last_cycles == LSCT_CYC_ONE;
	endproperty
	a_bst_run: assert property (p_bst_run) else $error("pipelined bus store not 1 cycle");

	property p_mulwh;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_MULWH |=> done && wide_product == 48'($past(mul_a)) * 48'($past(mul_b));
	endproperty
	a_mulwh: assert property (p_mulwh) else $error("wide multiply not single cycle");

	property p_low_flag;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_SSRF && issue_flag_bit < LSCT_UPPER_BIT
			|=> done && last_cycles == LSCT_CYC_ONE;
	endproperty
	a_low_flag: assert property (p_low_flag) else $error("lower flag set not 1 cycle");

	property p_other_sysreg;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_MTSR && issue_sysreg != LSCT_STATUS_SYSREG
			|=> done && last_cycles == LSCT_CYC_ONE;
	endproperty
	a_other_sysreg: assert property (p_other_sysreg) else $error("sysreg move not 1 cycle");

	property p_mac_hit;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_MAC && acc_hit
			|=> done && last_cycles == LSCT_CYC_ONE;
	endproperty
	a_mac_hit: assert property (p_mac_hit) else $error("cached accumulate not 1 cycle");

	property p_mac_miss;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_MAC && !acc_hit
			|=> last_cycles == LSCT_CYC_TWO ##1 done;
	endproperty
	a_mac_miss: assert property (p_mac_miss) else $error("uncached accumulate not 2 cycles");

	property p_macsd_miss;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_MACSD && !acc_hit
			|=> last_cycles == LSCT_CYC_FOUR ##3 done;
	endproperty
	a_macsd_miss: assert property (p_macsd_miss) else $error("uncached double accumulate not 4 cycles");

	property p_ldpi;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_LDPI && rmw_shadow_r == 2'b00
			|=> last_cycles == LSCT_CYC_TWO ##1 done;
	endproperty
	a_ldpi: assert property (p_ldpi) else $error("post-increment load not 2 cycles");

	property p_local_store;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_ST && !issue_bus && rmw_shadow_r == 2'b00
			|=> done && last_cycles == LSCT_CYC_ONE;
	endproperty
	a_local_store: assert property (p_local_store) else $error("local store not 1 cycle");

	property p_lone_bst;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_ST && issue_bus && bst_shadow_r == 2'b00 && rmw_shadow_r == 2'b00
			|=> done && last_cycles == LSCT_CYC_ONE;
	endproperty
	a_lone_bst: assert property (p_lone_bst) else $error("lone bus store not 1 cycle");

	property p_bst_first;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_ST && issue_bus && !prev_bst_r && bst_shadow_r != 2'b00 && rmw_shadow_r == 2'b00
			|=> last_cycles == LSCT_CYC_TWO ##1 done;
	endproperty
	a_bst_first: assert property (p_bst_first) else $error("first bus store of run not 2 cycles");

	property p_after_run;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_ALU && prev_bst_r
			|=> done && last_cycles == LSCT_CYC_ONE;
	endproperty
	a_after_run: assert property (p_after_run) else $error("op after bus store run stalled");

	property p_ldm_bus;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_LDM && issue_bus && rmw_shadow_r == 2'b00
			|=> last_cycles == LSCT_CNT_W'(LSCT_CYC_ONE + ($past(regs) << 1));
	endproperty
	a_ldm_bus: assert property (p_ldm_bus) else $error("bus load-multiple count wrong");

	property p_stm_bus;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_STM && issue_bus && rmw_shadow_r == 2'b00
			|=> last_cycles == LSCT_CNT_W'(LSCT_CYC_TWO + $past(regs));
	endproperty
	a_stm_bus: assert property (p_stm_bus) else $error("bus store-multiple count wrong");

	property p_rmw_ws;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_RMW && issue_bus && rmw_shadow_r == 2'b00
			|=> last_cycles == LSCT_CNT_W'(LSCT_CYC_ONE + $past(rmw_ws));
	endproperty
	a_rmw_ws: assert property (p_rmw_ws) else $error("bus atomic not stretched by wait states");

	property p_rmw_gap_one;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_LD && !issue_bus && rmw_shadow_r == 2'h2
			|=> last_cycles == LSCT_CYC_THREE;
	endproperty
	a_rmw_gap_one: assert property (p_rmw_gap_one) else $error("access one slot after bus atomic not stalled 2");

	property p_rmw_gap_two;
		@(posedge clk) disable iff (!rst_n_r)
		taken && issue_op == LSCT_OP_LD && !issue_bus && rmw_shadow_r == 2'h1
			|=> last_cycles == LSCT_CYC_TWO;
	endproperty
	a_rmw_gap_two: assert property (p_rmw_gap_two) else $error("access two slots after bus atomic not stalled 1");

endmodule : lsct_core

// ### sim/lsct_mem_model.sv
// Far-side memory model: wait states inserted by the system bus section
`timescale 1ns/1ps
module lsct_mem_model (
	nrst,
	ws_req,
	bus_wait_states
);
	import lsct_pkg::*;
	input  wire logic                           nrst;
	input  wire logic [lsct_pkg::LSCT_WS_W-1:0] ws_req;
	output logic      [lsct_pkg::LSCT_WS_W-1:0] bus_wait_states;
	// Zero wait unless the bench asks for a slow answer
	assign bus_wait_states = nrst ? ws_req : '0;
endmodule : lsct_mem_model

// ### sim/load_store_cycle_timing_bench.sv
// Self-checking bench for the load/store cycle timing block
`timescale 1ns/1ps
module load_store_cycle_timing_bench;
	import lsct_pkg::*;
	typedef struct {lsct_op_t op; logic bus; logic [7:0] arg; logic [3:0] ws; logic [5:0] ex;} lsct_ent_t;
	logic        clk, nrst, issue_valid, issue_ready, issue_bus, done, wb_busy, stalled;
	lsct_op_t    issue_op;
	logic [7:0]  arg;
	logic [3:0]  ws_req, bus_wait_states;
	logic [31:0] mul_a;
	logic [15:0] mul_b;
	logic [5:0]  last_cycles;
	logic [47:0] wide_product;
	int          mismatches, num_checks, seed, k, n;
	lsct_ent_t   q[$];

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	lsct_mem_model mem (.nrst(nrst), .ws_req(ws_req), .bus_wait_states(bus_wait_states));

	lsct_core dut (.clk(clk), .nrst(nrst), .issue_valid(issue_valid), .issue_ready(issue_ready),
		.issue_op(issue_op), .issue_bus(issue_bus), .issue_flag_bit(arg[4:0]), .issue_sysreg(arg),
		.issue_acc_reg(arg[3:0]), .issue_reg_count(arg[4:0]), .mul_a(mul_a), .mul_b(mul_b),
		.bus_wait_states(bus_wait_states), .done(done), .last_cycles(last_cycles),
		.wide_product(wide_product), .wb_busy(wb_busy), .stalled(stalled));

	task check(input logic [47:0] seen, input logic [47:0] expv);
		num_checks++;
		if (seen !== expv) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, expv);
		end
	endtask : check

	task give_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	function void add(lsct_op_t op, logic bus, logic [7:0] a, logic [5:0] e, logic [3:0] w = 4'h0);
		q.push_back('{op, bus, a, w, e});
	endfunction : add

	function logic [5:0] ldm_cyc(logic bus, logic [5:0] r);
		return bus ? 6'h01 + 6'h02 * r : 6'h01 + r;
	endfunction : ldm_cyc

	function logic [5:0] shadow_cyc(int gap);
		return (gap < 3) ? 6'(4 - gap) : 6'h01;
	endfunction : shadow_cyc

	task present(input int i);
		issue_valid <= 1'b1;
		issue_op    <= q[i].op;
		issue_bus   <= q[i].bus;
		arg         <= q[i].arg;
		ws_req      <= q[i].ws;
		mul_a       <= $random(seed) & 32'h7FFFFFFF;
		mul_b       <= $random(seed) & 16'h7FFF;
	endtask : present

	initial begin
		{nrst, issue_valid, issue_bus, arg, ws_req, mul_a, mul_b} = '0;
		issue_op = LSCT_OP_ALU;
		seed = 4115;
		add(LSCT_OP_ALU, 0, 0, 1);
		add(LSCT_OP_SSRF, 0, 8'h00, 1); add(LSCT_OP_SSRF, 0, 8'h0F, 1);
		add(LSCT_OP_SSRF, 0, 8'h10, 3); add(LSCT_OP_SSRF, 0, 8'h1F, 3);
		add(LSCT_OP_MTSR, 0, LSCT_STATUS_SYSREG, 3); add(LSCT_OP_MTSR, 0, 8'h01, 1);
		add(LSCT_OP_MAC, 0, 5, 2); add(LSCT_OP_MAC, 0, 5, 1); add(LSCT_OP_MAC, 0, 3, 2);
		add(LSCT_OP_MAC, 0, 3, 1); add(LSCT_OP_MACSD, 0, 2, 4);
		repeat (3) add(LSCT_OP_MULWH, 0, 0, 1);
		add(LSCT_OP_ST, 0, 0, 1); add(LSCT_OP_LDPI, 0, 0, 2); add(LSCT_OP_ALU, 0, 0, 1);
		add(LSCT_OP_LD, 0, 0, 1); add(LSCT_OP_ALU, 0, 0, 1); add(LSCT_OP_LD, 0, 0, 1);
		add(LSCT_OP_LD, 0, 0, 1); add(LSCT_OP_LDM, 0, 4, ldm_cyc(0, 4));
		add(LSCT_OP_ST, 0, 0, 1); add(LSCT_OP_ST, 0, 0, 1); add(LSCT_OP_ALU, 0, 0, 1);
		add(LSCT_OP_LD, 1, 0, 2); add(LSCT_OP_LD, 1, 0, 2);
		add(LSCT_OP_ST, 1, 0, 1); add(LSCT_OP_ALU, 0, 0, 1); add(LSCT_OP_ALU, 0, 0, 1);
		add(LSCT_OP_ST, 1, 0, 2); add(LSCT_OP_ST, 1, 0, 1); add(LSCT_OP_ST, 1, 0, 1);
		add(LSCT_OP_ALU, 0, 0, 1); add(LSCT_OP_LDM, 1, 4, ldm_cyc(1, 4));
		add(LSCT_OP_STM, 1, 4, 6); add(LSCT_OP_ALU, 0, 0, 1);
		add(LSCT_OP_RMW, 0, 0, 1); add(LSCT_OP_ST, 0, 0, 1); add(LSCT_OP_RMW, 0, 0, 2);
		add(LSCT_OP_ALU, 0, 0, 1); add(LSCT_OP_RMW, 1, 0, 1); add(LSCT_OP_LD, 0, 0, shadow_cyc(0));
		add(LSCT_OP_RMW, 1, 0, 1);
		repeat (3) add(LSCT_OP_ALU, 0, 0, 1);
		repeat (4) begin
			n = 1 + ($unsigned($random(seed)) % 8);
			add(LSCT_OP_LDM, 0, 8'(n), ldm_cyc(0, 6'(n)));
			add(LSCT_OP_LDM, 1, 8'(n), ldm_cyc(1, 6'(n)));
			add(LSCT_OP_STM, 1, 8'(n), 6'(2 + n));
			repeat (3) add(LSCT_OP_ALU, 0, 0, 1);
			n = $unsigned($random(seed)) % 4;
			add(LSCT_OP_RMW, 1, 0, 6'(1 + n), 4'(n));
			repeat (3) add(LSCT_OP_ALU, 0, 0, 1);
			n = $unsigned($random(seed)) % 4;
			add(LSCT_OP_RMW, 1, 0, 1);
			repeat (n) add(LSCT_OP_ALU, 0, 0, 1);
			add(LSCT_OP_LD, 0, 0, shadow_cyc(n));
		end
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		for (int i = 0; i < q.size(); i++) begin
			present(i);
			for (k = 1; k <= 40; k++) begin
				@(posedge clk);
				#1;
				if (done === 1'b1) break;
			end
			if (k > 40) begin
				mismatches++;
				give_verdict();
			end
			check(48'(last_cycles), 48'(q[i].ex));
			if (q[i].op == LSCT_OP_MULWH) check(wide_product, 48'(mul_a) * 48'(mul_b));
			check(48'(k), 48'(q[i].ex));
		end
		issue_valid <= 1'b0;
		give_verdict();
	end
endmodule : load_store_cycle_timing_bench
